// >>> hw/tlfc_defines.vh
`ifndef TLFC_DEFINES_VH
`define TLFC_DEFINES_VH

// Register byte offsets in the port configuration space.
`define TLFC_OFS_FWD_CTRL 12'h4c4
`define TLFC_OFS_FEATURE 12'h4c8
`define TLFC_OFS_RING_DBG 12'h4cc
`define TLFC_OFS_DBG_SEL 12'h4d0
`define TLFC_OFS_STRAP0 12'h504

// Field positions of forwarding_control.
`define TLFC_FC_ARB_MODE 4
`define TLFC_FC_EGR_ORDER 5
`define TLFC_FC_CPL_ORDER 6
`define TLFC_FC_NP_STORE 7
`define TLFC_FC_DATASEL_WR 9
`define TLFC_FC_BOUNDARY 11
`define TLFC_FC_P_NO_PASS 13
`define TLFC_FC_FROZEN_P 14
`define TLFC_FC_FROZEN_NP 15

// Field positions of feature_enables.
`define TLFC_FE_DMA 0
`define TLFC_FE_NONTRANS 1
`define TLFC_FE_PWR_SAVE 2
`define TLFC_FE_OVERLAY 4
`define TLFC_FE_EGR_REQ 5

// Field positions of device_strap_config_0.
`define TLFC_SC_UPPORT_LSB 0
`define TLFC_SC_CROSS_DOM 6
`define TLFC_SC_SMBUS 7
`define TLFC_SC_I2CADR_LSB 8

// Writable masks (software side) and loader-writable masks.
`define TLFC_FC_SW_MASK 32'h0007edf0
`define TLFC_FC_LD_MASK 32'h0007eff0
`define TLFC_FE_SW_MASK 32'h000000f8
`define TLFC_FE_LD_MASK 32'h000000ff
`define TLFC_RD_LD_MASK 32'h0000001f
`define TLFC_DS_SW_MASK 32'hff000000
`define TLFC_SC_LD_MASK 32'h00000047

// Reset values.
`define TLFC_FC_RESET 32'h00008000
`define TLFC_FE_RESET 32'h00000016
`define TLFC_RD_RESET 32'h0000000a
`define TLFC_DS_RESET 32'h00000000
`define TLFC_SC_RESET 32'h00000000

`endif

// >>> hw/tlfc_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for strap pins arriving from outside the clock domain.
module tlfc_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire nrst,
  input wire [W-1:0] asyncIn,
  output reg [W-1:0] syncOut
);
  reg [W-1:0] stage1_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1_r <= {W{1'b0}};
      syncOut <= {W{1'b0}};
    end else begin
      stage1_r <= asyncIn;
      syncOut <= stage1_r;
    end
  end
endmodule // tlfc_sync

// >>> hw/tlfc_port_arb.v
`timescale 1ns/1ps
// Round-robin port arbiter steered by the arbitration mode bit.
module tlfc_port_arb #(
  parameter PORTS = 4
) (
  input wire clk,
  input wire nrst,
  input wire stickyMode,
  input wire [PORTS-1:0] portReq,
  input wire [PORTS-1:0] creditOk,
  output reg [PORTS-1:0] grant
);
  reg [PORTS-1:0] grantNxt;
  reg [PORTS-1:0] eligible;

  // Picks the first eligible port after the current grant, wrapping round.
  function [PORTS-1:0] rrPick;
    input [PORTS-1:0] elig;
    input [PORTS-1:0] cur;
    integer i;
    integer j;
    integer last;
    reg found;
    begin
      rrPick = {PORTS{1'b0}};
      found = 1'b0;
      last = PORTS - 1;
      for (i = 0; i < PORTS; i = i + 1) begin
        if (cur[i]) begin
          last = i;
        end
      end
      for (i = 1; i <= PORTS; i = i + 1) begin
        j = (last + i) % PORTS;
        if (!found && elig[j]) begin
          rrPick[j] = 1'b1;
          found = 1'b1;
        end
      end
    end
  endfunction

  always @* begin
    eligible = stickyMode ? portReq : (portReq & creditOk);
    if (stickyMode && |(grant & portReq)) begin
      grantNxt = grant;
    end else if (!stickyMode && |(grant & portReq & creditOk)) begin
      grantNxt = grant;
    end else begin
      grantNxt = rrPick(eligible, grant);
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      grant <= {PORTS{1'b0}};
    end else begin
      grant <= grantNxt;
    end
  end
endmodule // tlfc_port_arb

// >>> hw/tlfc_config_regs.v
// Summary of operation
// - Arbitration mode set: stay on granted port while it requests; else credit-checked.
// - Egress ordering bit forces ordering among packets to different egress ports.
// - Completion ordering bit orders completions of differing tags, upstream port only.
// - Non-posted store bit set selects store-and-forward; clear selects cut-through.
// - Data-select writability bit at one makes the PM data-select field writable.
// - 4KB boundary crossing check runs only while its bit is one; resets to zero.
// - Posted-ordering restriction set stops posted packets passing non-posted ones.
// - Separate frozen-ordering disables: posted resets 0, non-posted resets 1.
// - Read-only DMA capability bit reads one when DMA is enabled; resets to zero.
// - Read-only non-transparent bit reads one when enabled; resets to one.
// - Power saving enable, reset one, acts switch-wide from the port 0 copy only.
// - Egress request mode bit, reset zero, acts switch-wide from port 0 only.
// - Overlay credit update select, reset one, picks overlay flow-control update mode.
// - Cross-domain bit one gives cross-domain operation, zero transparent; resets zero.
// - Three-bit upstream port select, reset zero, valid only in transparent mode.
// - Management bus select mirrors a strap: zero is I2C, one is SMBus.
`timescale 1ns/1ps
`include "tlfc_defines.vh"
module tlfc_config_regs #(
  parameter PORT_ID = 0,
  parameter PORTS = 4
) (
  input wire clk,
  input wire nrst,
  input wire [11:0] cfgAddr,
  input wire cfgWr,
  input wire cfgRd,
  input wire [3:0] cfgByteEn,
  input wire [31:0] cfgWrData,
  output reg [31:0] cfgRdData,
  output reg cfgRdValid,
  input wire ldWr,
  input wire [11:0] ldAddr,
  input wire [31:0] ldData,
  input wire smbusStrap,
  input wire [2:0] i2cAddrStrap,
  input wire portIsUpstream,
  input wire [PORTS-1:0] portReq,
  input wire [PORTS-1:0] creditOk,
  output wire [PORTS-1:0] portGrant,
  output reg egressOrderForced,
  output reg cplOrderForced,
  output reg nonposted_store_forward,
  output reg nonpostedCutThrough,
  output reg dataSelWritable,
  output reg boundary_cross_check_on,
  output reg posted_no_pass_nonposted,
  output reg frozenOrderOffPosted,
  output reg frozen_order_off_nonposted,
  output reg dmaEnabled,
  output reg nonTransparentOn,
  output reg powerSaveOn,
  output reg egressRequestMode,
  output reg overlay_credit_update_select,
  output reg cross_domain_global,
  output reg [2:0] upPortSelect,
  output reg upPortSelectValid,
  output reg mgmtBusSmbus
);
  localparam [0:0] IS_PORT0 = (PORT_ID == 0);

  reg [31:0] fwdCtrl_r;
  reg [31:0] fwdCtrl_nxt;
  reg [31:0] feature_r;
  reg [31:0] feature_nxt;
  reg [31:0] ringDbg_r;
  reg [31:0] ringDbg_nxt;
  reg [31:0] dbgSel_r;
  reg [31:0] dbgSel_nxt;
  reg [31:0] strap0_r;
  reg [31:0] strap0_nxt;
  reg [31:0] rdMux;
  wire [31:0] byteMask;
  wire smbusSync;
  wire [2:0] i2cAddrSync;
  reg arbSticky_r;

  // Merges a write into a register under a mask of the bits that may change.
  function [31:0] mergeBits;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [31:0] mask;
    begin
      mergeBits = (oldVal & ~mask) | (newVal & mask);
    end
  endfunction

  assign byteMask = {{8{cfgByteEn[3]}}, {8{cfgByteEn[2]}}, {8{cfgByteEn[1]}},
    {8{cfgByteEn[0]}}};

  tlfc_sync #(
    .W(4)
  ) u_strapSync (
    .clk(clk),
    .nrst(nrst),
    .asyncIn({smbusStrap, i2cAddrStrap}),
    .syncOut({smbusSync, i2cAddrSync})
  );

  tlfc_port_arb #(
    .PORTS(PORTS)
  ) u_portArb (
    .clk(clk),
    .nrst(nrst),
    .stickyMode(arbSticky_r),
    .portReq(portReq),
    .creditOk(creditOk),
    .grant(portGrant)
  );

  // Software writes touch only RW bits; the loader may also preset RO fields.
  // A loader write in the same cycle as a software write to one register wins.
  always @* begin
    fwdCtrl_nxt = fwdCtrl_r;
    feature_nxt = feature_r;
    ringDbg_nxt = ringDbg_r;
    dbgSel_nxt = dbgSel_r;
    strap0_nxt = strap0_r;
    if (cfgWr) begin
      case (cfgAddr)
        `TLFC_OFS_FWD_CTRL: begin
          fwdCtrl_nxt = mergeBits(fwdCtrl_r, cfgWrData, `TLFC_FC_SW_MASK & byteMask);
        end
        `TLFC_OFS_FEATURE: begin
          feature_nxt = mergeBits(feature_r, cfgWrData, `TLFC_FE_SW_MASK & byteMask);
        end
        `TLFC_OFS_DBG_SEL: begin
          dbgSel_nxt = mergeBits(dbgSel_r, cfgWrData, `TLFC_DS_SW_MASK & byteMask);
        end
        default: begin
          fwdCtrl_nxt = fwdCtrl_r;
        end
      endcase
    end
    if (ldWr) begin
      case (ldAddr)
        `TLFC_OFS_FWD_CTRL: begin
          fwdCtrl_nxt = mergeBits(fwdCtrl_nxt, ldData, `TLFC_FC_LD_MASK);
        end
        `TLFC_OFS_FEATURE: begin
          feature_nxt = mergeBits(feature_nxt, ldData, `TLFC_FE_LD_MASK);
        end
        `TLFC_OFS_RING_DBG: begin
          ringDbg_nxt = mergeBits(ringDbg_r, ldData, `TLFC_RD_LD_MASK);
        end
        `TLFC_OFS_DBG_SEL: begin
          dbgSel_nxt = mergeBits(dbgSel_nxt, ldData, `TLFC_DS_SW_MASK);
        end
        `TLFC_OFS_STRAP0: begin
          strap0_nxt = mergeBits(strap0_r, ldData, `TLFC_SC_LD_MASK);
        end
        default: begin
        end
      endcase
    end
    // Strap-mirrored fields follow the synchronised pins.
    strap0_nxt[`TLFC_SC_SMBUS] = smbusSync;
    strap0_nxt[`TLFC_SC_I2CADR_LSB +: 3] = i2cAddrSync;
  end

  always @* begin
    case (cfgAddr)
      `TLFC_OFS_FWD_CTRL: rdMux = fwdCtrl_r;
      `TLFC_OFS_FEATURE: rdMux = feature_r;
      `TLFC_OFS_RING_DBG: rdMux = ringDbg_r;
      `TLFC_OFS_DBG_SEL: rdMux = dbgSel_r;
      `TLFC_OFS_STRAP0: rdMux = strap0_r;
      default: rdMux = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fwdCtrl_r <= `TLFC_FC_RESET;
      feature_r <= `TLFC_FE_RESET;
      ringDbg_r <= `TLFC_RD_RESET;
      dbgSel_r <= `TLFC_DS_RESET;
      strap0_r <= `TLFC_SC_RESET;
      cfgRdData <= 32'h00000000;
      cfgRdValid <= 1'b0;
    end else begin
      fwdCtrl_r <= fwdCtrl_nxt;
      feature_r <= feature_nxt;
      ringDbg_r <= ringDbg_nxt;
      dbgSel_r <= dbgSel_nxt;
      strap0_r <= strap0_nxt;
      cfgRdValid <= cfgRd;
      if (cfgRd) begin
        cfgRdData <= rdMux;
      end
    end
  end

  // Control outputs are registered from the stored fields; two are inverted, three gated.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arbSticky_r <= 1'b0;
      egressOrderForced <= 1'b0;
      cplOrderForced <= 1'b0;
      nonposted_store_forward <= 1'b0;
      nonpostedCutThrough <= 1'b1;
      dataSelWritable <= 1'b0;
      boundary_cross_check_on <= 1'b0;
      posted_no_pass_nonposted <= 1'b0;
      frozenOrderOffPosted <= 1'b0;
      frozen_order_off_nonposted <= 1'b1;
      dmaEnabled <= 1'b0;
      nonTransparentOn <= 1'b1;
      powerSaveOn <= IS_PORT0 ? 1'b1 : 1'b0;
      egressRequestMode <= 1'b0;
      overlay_credit_update_select <= 1'b1;
      cross_domain_global <= 1'b0;
      upPortSelect <= 3'h0;
      upPortSelectValid <= 1'b1;
      mgmtBusSmbus <= 1'b0;
    end else begin
      arbSticky_r <= fwdCtrl_r[`TLFC_FC_ARB_MODE];
      egressOrderForced <= fwdCtrl_r[`TLFC_FC_EGR_ORDER];
      cplOrderForced <= fwdCtrl_r[`TLFC_FC_CPL_ORDER] & portIsUpstream;
      nonposted_store_forward <= fwdCtrl_r[`TLFC_FC_NP_STORE];
      nonpostedCutThrough <= ~fwdCtrl_r[`TLFC_FC_NP_STORE];
      dataSelWritable <= fwdCtrl_r[`TLFC_FC_DATASEL_WR];
      boundary_cross_check_on <= fwdCtrl_r[`TLFC_FC_BOUNDARY];
      posted_no_pass_nonposted <= fwdCtrl_r[`TLFC_FC_P_NO_PASS];
      frozenOrderOffPosted <= fwdCtrl_r[`TLFC_FC_FROZEN_P];
      frozen_order_off_nonposted <= fwdCtrl_r[`TLFC_FC_FROZEN_NP];
      dmaEnabled <= feature_r[`TLFC_FE_DMA];
      nonTransparentOn <= feature_r[`TLFC_FE_NONTRANS];
      powerSaveOn <= feature_r[`TLFC_FE_PWR_SAVE] & IS_PORT0;
      egressRequestMode <= feature_r[`TLFC_FE_EGR_REQ] & IS_PORT0;
      overlay_credit_update_select <= feature_r[`TLFC_FE_OVERLAY];
      cross_domain_global <= strap0_r[`TLFC_SC_CROSS_DOM];
      upPortSelect <= strap0_r[`TLFC_SC_UPPORT_LSB +: 3];
      upPortSelectValid <= ~strap0_r[`TLFC_SC_CROSS_DOM];
      mgmtBusSmbus <= strap0_r[`TLFC_SC_SMBUS];
    end
  end
endmodule // tlfc_config_regs

// >>> dv/tlfc_config_regs_props.sv
`timescale 1ns/1ps
module tlfc_config_regs_props #(
  parameter PORTS = 4
) (
  input wire clk,
  input wire nrst,
  input wire [11:0] cfgAddr,
  input wire cfgWr,
  input wire cfgRd,
  input wire [3:0] cfgByteEn,
  input wire [31:0] cfgWrData,
  input wire [31:0] cfgRdData,
  input wire cfgRdValid,
  input wire ldWr,
  input wire portIsUpstream,
  input wire [PORTS-1:0] portGrant,
  input wire egressOrderForced,
  input wire cplOrderForced,
  input wire nonposted_store_forward,
  input wire nonpostedCutThrough,
  input wire boundary_cross_check_on,
  input wire cross_domain_global,
  input wire upPortSelectValid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // A software write to forwarding_control that sets one bit to v, with no loader write.
  sequence sFcWr(b, v);
    cfgWr && !ldWr && cfgAddr == 12'h4c4 && cfgByteEn[b / 8] && cfgWrData[b] == v;
  endsequence

  a_read_answer: assert property (cfgRd |=> cfgRdValid)
    else $error("read not answered after one cycle");
  a_read_hold: assert property (!cfgRd |=> !cfgRdValid && $stable(cfgRdData))
    else $error("read data or valid moved without a read");
  a_unmapped_zero: assert property (cfgRd && cfgAddr == 12'h4d4 |=> cfgRdData == 32'h0)
    else $error("unmapped read not zero");
  a_egr_order_set: assert property (sFcWr(5, 1) |-> ##2 egressOrderForced)
    else $error("egress ordering not applied after write");
  a_np_cut_clear: assert property (sFcWr(7, 0) |-> ##2 nonpostedCutThrough)
    else $error("cut-through not selected after clear");
  a_np_mode_excl: assert property (nonposted_store_forward != nonpostedCutThrough)
    else $error("store and cut-through modes agree");
  a_boundary_set: assert property (sFcWr(11, 1) |-> ##2 boundary_cross_check_on)
    else $error("boundary check not enabled after write");
  a_cpl_upstream: assert property (!portIsUpstream |=> !cplOrderForced)
    else $error("completion ordering on a downstream port");
  a_cross_excl: assert property (cross_domain_global != upPortSelectValid)
    else $error("upstream select valid in cross-domain mode");
  a_grant_onehot: assert property ($onehot0(portGrant))
    else $error("grant not one-hot");
endmodule // tlfc_config_regs_props

bind tlfc_config_regs tlfc_config_regs_props #(.PORTS(PORTS)) uProps (.*);

// >>> dv/tl_forwarding_config_regs_tb.sv
`timescale 1ns/1ps
module tl_forwarding_config_regs_tb;
  reg clk, nrst, cfgWr, cfgRd, ldWr, smbusStrap, portIsUpstream;
  reg [11:0] cfgAddr, ldAddr;
  reg [3:0] cfgByteEn, portReq, creditOk;
  reg [31:0] cfgWrData, ldData;
  reg [2:0] i2cAddrStrap;
  wire [31:0] cfgRdData;
  wire [3:0] portGrant;
  wire [2:0] upPortSelect;
  wire cfgRdValid, egressOrderForced, cplOrderForced, nonposted_store_forward;
  wire nonpostedCutThrough, dataSelWritable, boundary_cross_check_on;
  wire posted_no_pass_nonposted, frozenOrderOffPosted, frozen_order_off_nonposted;
  wire dmaEnabled, nonTransparentOn, powerSaveOn, egressRequestMode;
  wire overlay_credit_update_select, cross_domain_global, upPortSelectValid, mgmtBusSmbus;
  integer fail_count = 0;
  integer checks_done = 0;
  // All level outputs in one vector, most significant first.
  wire [19:0] outs = {egressOrderForced, cplOrderForced, nonposted_store_forward,
    nonpostedCutThrough, dataSelWritable, boundary_cross_check_on, posted_no_pass_nonposted,
    frozenOrderOffPosted, frozen_order_off_nonposted, dmaEnabled, nonTransparentOn,
    powerSaveOn, egressRequestMode, overlay_credit_update_select, cross_domain_global,
    upPortSelectValid, mgmtBusSmbus, upPortSelect};

  tlfc_config_regs #(.PORT_ID(0), .PORTS(4)) uut (.*);

  task chk(input [8*8-1:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task wr(input [11:0] a, input [3:0] be, input [31:0] d);
    begin
      @(posedge clk);
      cfgWr <= 1'b1;
      cfgAddr <= a;
      cfgByteEn <= be;
      cfgWrData <= d;
      @(posedge clk);
      cfgWr <= 1'b0;
    end
  endtask

  task ld(input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      ldWr <= 1'b1;
      ldAddr <= a;
      ldData <= d;
      @(posedge clk);
      ldWr <= 1'b0;
    end
  endtask

  task rd(input [11:0] a, input [31:0] e);
    begin
      @(posedge clk);
      cfgRd <= 1'b1;
      cfgAddr <= a;
      @(posedge clk);
      cfgRd <= 1'b0;
      #1;
      chk("rdvalid", cfgRdValid, 1'b1);
      chk("rddata", cfgRdData, e);
    end
  endtask

  task settle;
    begin
      repeat (2) @(posedge clk);
      #1;
    end
  endtask

  task arb(input [3:0] r, input [3:0] c, input [3:0] e);
    begin
      @(posedge clk);
      portReq <= r;
      creditOk <= c;
      @(posedge clk);
      #1;
      chk("grant", portGrant, e);
    end
  endtask

  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #1000000;
    fail_count = fail_count + 1;
    complete_run;
  end

  initial begin
    nrst = 1'b0;
    {cfgWr, cfgRd, ldWr} = 3'h0;
    {cfgAddr, ldAddr, cfgByteEn, cfgWrData, ldData} = 92'h0;
    {portReq, creditOk} = 8'h00;
    smbusStrap = 1'b1;
    i2cAddrStrap = 3'h5;
    portIsUpstream = 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(12'h4c4, 32'h00008000);
    rd(12'h4c8, 32'h00000016);
    rd(12'h4cc, 32'h0000000a);
    rd(12'h4d0, 32'h00000000);
    rd(12'h504, 32'h00000580);
    chk("outs", outs, 20'h10b58);
    $display("test reset values done");
    wr(12'h4c4, 4'hf, 32'hffffffff);
    wr(12'h4c8, 4'hf, 32'hffffffff);
    wr(12'h4cc, 4'hf, 32'hffffffff);
    wr(12'h4d0, 4'hf, 32'hffffffff);
    wr(12'h4d4, 4'hf, 32'hffffffff);
    rd(12'h4c4, 32'h0007edf0);
    rd(12'h4c8, 32'h000000fe);
    rd(12'h4cc, 32'h0000000a);
    rd(12'h4d0, 32'hff000000);
    rd(12'h4d4, 32'h00000000);
    settle;
    chk("outs", outs, 20'he7bd8);
    $display("test software writes done");
    @(posedge clk);
    portIsUpstream <= 1'b0;
    wr(12'h4c4, 4'h1, 32'h00000000);
    rd(12'h4c4, 32'h0007ed00);
    settle;
    chk("outs", outs, 20'h17bd8);
    wr(12'h4c4, 4'hf, 32'h00000000);
    rd(12'h4c4, 32'h00000000);
    $display("test byte lanes done");
    ld(12'h4c8, 32'h00000001);
    ld(12'h504, 32'h00000047);
    ld(12'h4c4, 32'h00000200);
    rd(12'h504, 32'h000005c7);
    rd(12'h4c4, 32'h00000200);
    ld(12'h4cc, 32'hffffffff);
    rd(12'h4cc, 32'h0000001f);
    ld(12'h4d0, 32'h5affffff);
    rd(12'h4d0, 32'h5a000000);
    settle;
    chk("outs", outs, 20'h1842f);
    $display("test loader writes done");
    arb(4'h1, 4'h1, 4'h1);
    arb(4'h3, 4'h2, 4'h2);
    wr(12'h4c4, 4'h1, 32'h00000010);
    settle;
    arb(4'h3, 4'h0, 4'h2);
    arb(4'h1, 4'h0, 4'h1);
    $display("test arbitration done");
    complete_run;
  end
endmodule // tl_forwarding_config_regs_tb
